// >>> hdl/pab_pkg.sv
// register map, field layout and helpers for the port arbitration and
// power budget register bank.
// assumes a 32-bit apb slave with a 12-bit byte address.
package pab_pkg;

  // ----------------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_ARB_TABLE_WORD_1 = 12'h224;
  localparam logic [11:0] OFF_ARB_TABLE_WORD_2 = 12'h228;
  localparam logic [11:0] OFF_ARB_TABLE_WORD_3 = 12'h22c;
  localparam logic [11:0] OFF_BUDGET_CAP_HDR   = 12'h280;
  localparam logic [11:0] OFF_BUDGET_DATA_SEL  = 12'h284;
  localparam logic [11:0] OFF_BUDGET_READBACK  = 12'h288;
  localparam logic [11:0] OFF_BUDGET_UNLOCK    = 12'h290;
  localparam logic [11:0] OFF_BUDGET_WORD_BASE = 12'h300;
  localparam logic [11:0] OFF_BUDGET_WORD_LAST = 12'h31c;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int SLOT_W          = 4;
  localparam int SLOTS_PER_WORD  = 8;
  localparam int TABLE_WORDS     = 3;
  localparam int FIRST_SLOT      = 8;
  localparam int CAP_ID_LSB      = 0;
  localparam int CAP_ID_W        = 16;
  localparam int CAP_VER_LSB     = 16;
  localparam int CAP_VER_W       = 4;
  localparam int NEXT_PTR_LSB    = 20;
  localparam int NEXT_PTR_W      = 12;
  localparam int SEL_W           = 8;
  localparam int WORD_IDX_W      = 3;
  localparam int BUDGET_WORDS    = 8;
  localparam int UNLOCK_BIT      = 0;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [31:0] TABLE_RESET    = 32'h0000_0000;
  localparam logic [31:0] CAP_HDR_RESET  = 32'h0000_0000;
  localparam logic [7:0]  SEL_RESET      = 8'h00;
  localparam logic [7:0]  SEL_LAST_WORD  = 8'h07;
  localparam logic [15:0] CAP_ID_BUDGET  = 16'h0004;
  localparam logic [3:0]  CAP_VER_ONE    = 4'h1;
  localparam logic [3:0]  PORT_UPSTREAM  = 4'h0;
  localparam logic [3:0]  PORT_TWO       = 4'h2;
  localparam logic [3:0]  PORT_FOUR      = 4'h4;

  // a slot naming a port outside this set is skipped by the arbiter
  function automatic logic validPort(input logic [3:0] code);
    validPort = (code == PORT_UPSTREAM) || (code == PORT_TWO) || (code == PORT_FOUR);
  endfunction

  // merge write data into an old word under the byte strobes
  function automatic logic [31:0] applyStrobe(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = newVal[8*b +: 8];
    end
    applyStrobe = res;
  endfunction

endpackage

// >>> hdl/pab_word_mem.sv
// eight-word store for the power budget data values.
// assumes writes are already qualified; contents are not reset.
`timescale 1ns/1ps
module pab_word_mem (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [31:0] wdata,
  // read port
  input  wire logic [2:0]  raddr,
  output logic      [31:0] rdata
);

  logic [31:0] store [0:7];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // no reset on the array: the words keep their value like sticky bits
  always_ff @(posedge clock)
  begin
    if (we)
      store[waddr] <= wdata;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else
      rdata <= store[raddr];
  end

endmodule

// >>> hdl/pab_slot_check.sv
// flags which slots of one arbitration table word name a usable port.
// assumes the word comes straight from the table registers.
`timescale 1ns/1ps
module pab_slot_check (
  // table word
  input  wire logic [31:0] tableWord,
  // per-slot flags
  output logic      [7:0]  slotValid
);

  always_comb
  begin
    for (int s = 0; s < pab_pkg::SLOTS_PER_WORD; s++)
      slotValid[s] = pab_pkg::validPort(tableWord[s*pab_pkg::SLOT_W +: pab_pkg::SLOT_W]);
  end

endmodule

// >>> hdl/pab_regs.sv
// apb register bank: arbitration slots 8..31 and the power budget block.
// assumes a single clock, an apb3/4 master, and an external arbiter that
// reads the table and slot flags from the output ports.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// How it works
// - each table word holds eight 4-bit port slots, low nibble first, reset zero
// - slots 8 to 31 live in three consecutive words, slot n at nibble n mod 8
// - header bits 15:0 report the capability identifier once loaded
// - header bits 19:16 report the version, bits 31:20 the next pointer
// - the 8-bit selector picks which budget data word appears in the readback
// - slot codes 0, 2 and 4 are ports; other codes are skipped at once
// - a valid selector returns the budget data word of that index
// - budget data words accept writes only while the unlock bit is set
module pab_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // arbitration table towards the arbiter
  output logic      [95:0] arbTable,
  output logic      [23:0] arbSlotValid
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_ANSWER = 2'b10
  } pab_phase_type;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pab_phase_type phase_r;
  pab_phase_type phase_nxt;
  logic [31:0]   arbWord_r [0:2];
  logic [31:0]   capHdr_r;
  logic [7:0]    dataWordSelector_r;
  logic          budgetWordUnlock_r;
  logic [31:0]   prdata_r;
  logic [31:0]   prdata_nxt;
  logic          err_r;
  logic          err_nxt;
  logic [31:0]   memRdata;
  logic [2:0]    memRaddr;
  logic          memWe;
  logic          isBudgetWord;
  logic          isTable;
  logic [1:0]    tableIdx;
  logic          mapped;
  logic          wrTake;
  logic [31:0]   readbackVal;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  assign isBudgetWord = (paddr >= pab_pkg::OFF_BUDGET_WORD_BASE)
                     && (paddr <= pab_pkg::OFF_BUDGET_WORD_LAST)
                     && (paddr[1:0] == 2'b00);
  assign isTable      = (paddr == pab_pkg::OFF_ARB_TABLE_WORD_1)
                     || (paddr == pab_pkg::OFF_ARB_TABLE_WORD_2)
                     || (paddr == pab_pkg::OFF_ARB_TABLE_WORD_3);
  assign tableIdx     = 2'(paddr[3:2] - pab_pkg::OFF_ARB_TABLE_WORD_1[3:2]);
  assign mapped       = isTable || isBudgetWord
                     || (paddr == pab_pkg::OFF_BUDGET_CAP_HDR)
                     || (paddr == pab_pkg::OFF_BUDGET_DATA_SEL)
                     || (paddr == pab_pkg::OFF_BUDGET_READBACK)
                     || (paddr == pab_pkg::OFF_BUDGET_UNLOCK);

  // ----------------------------------------------------------------------
  // apb handshake: one wait state on every transfer
  // ----------------------------------------------------------------------
  // the wait state gives the memory read and the readback mux a flop each
  always_comb
  begin
    phase_nxt = phase_r;
    unique case (phase_r)
      ST_IDLE:   if (psel && !penable) phase_nxt = ST_FETCH;
      ST_FETCH:  phase_nxt = ST_ANSWER;
      ST_ANSWER: phase_nxt = ST_IDLE;
      default:   phase_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phase_r <= ST_IDLE;
    else
      phase_r <= phase_nxt;
  end

  assign pready  = psel && penable && (phase_r == ST_ANSWER);
  assign pslverr = pready && err_r;
  assign wrTake  = pready && pwrite && !err_r;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------------
  // read data and error capture
  // ----------------------------------------------------------------------
  assign readbackVal = (dataWordSelector_r > pab_pkg::SEL_LAST_WORD) ? 32'h0000_0000 : memRdata;

  always_comb
  begin
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    if (phase_r == ST_FETCH)
    begin
      err_nxt    = !mapped;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite)
      begin
        if (isTable)
          prdata_nxt = arbWord_r[tableIdx];
        else if (isBudgetWord)
          prdata_nxt = memRdata;
        else if (paddr == pab_pkg::OFF_BUDGET_CAP_HDR)
          prdata_nxt = capHdr_r;
        else if (paddr == pab_pkg::OFF_BUDGET_DATA_SEL)
          prdata_nxt = {24'h00_0000, dataWordSelector_r};
        else if (paddr == pab_pkg::OFF_BUDGET_READBACK)
          prdata_nxt = readbackVal;
        else if (paddr == pab_pkg::OFF_BUDGET_UNLOCK)
          prdata_nxt = {31'h0000_0000, budgetWordUnlock_r};
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // arbitration table
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int w = 0; w < pab_pkg::TABLE_WORDS; w++)
        arbWord_r[w] <= pab_pkg::TABLE_RESET;
    end
    else if (wrTake && isTable)
      arbWord_r[tableIdx] <= pab_pkg::applyStrobe(arbWord_r[tableIdx], pwdata, pstrb);
  end

  for (genvar g = 0; g < pab_pkg::TABLE_WORDS; g++)
  begin : g_word
    assign arbTable[g*32 +: 32] = arbWord_r[g];
    pab_slot_check u_check (
      .tableWord (arbWord_r[g]),
      .slotValid (arbSlotValid[g*8 +: 8])
    );
  end

  // ----------------------------------------------------------------------
  // capability header, selector, unlock
  // ----------------------------------------------------------------------
  // header fields are lockable: only a write while the unlock bit is set may change them
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      capHdr_r <= pab_pkg::CAP_HDR_RESET;
    else if (wrTake && (paddr == pab_pkg::OFF_BUDGET_CAP_HDR) && budgetWordUnlock_r)
      capHdr_r <= pab_pkg::applyStrobe(capHdr_r, pwdata, pstrb);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dataWordSelector_r <= pab_pkg::SEL_RESET;
    else if (wrTake && (paddr == pab_pkg::OFF_BUDGET_DATA_SEL) && pstrb[0])
      dataWordSelector_r <= pwdata[7:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      budgetWordUnlock_r <= 1'b0;
    else if (wrTake && (paddr == pab_pkg::OFF_BUDGET_UNLOCK) && pstrb[0])
      budgetWordUnlock_r <= pwdata[pab_pkg::UNLOCK_BIT];
  end

  // ----------------------------------------------------------------------
  // budget data words
  // ----------------------------------------------------------------------
  // the single read port serves direct reads while one is addressed,
  // otherwise it follows the selector for the readback register
  assign memRaddr = (psel && isBudgetWord) ? paddr[4:2] : dataWordSelector_r[2:0];
  assign memWe    = wrTake && isBudgetWord && budgetWordUnlock_r && (pstrb == 4'hf);

  pab_word_mem u_mem (
    .clock (clock),
    .rst   (rst),
    .we    (memWe),
    .waddr (paddr[4:2]),
    .wdata (pwdata),
    .raddr (memRaddr),
    .rdata (memRdata)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  table_write_a: assert property (
    wrTake && (paddr == pab_pkg::OFF_ARB_TABLE_WORD_2) && (pstrb == 4'hf)
      |=> arbTable[63:32] == $past(pwdata))
    else $error("table word 2 did not take write data");

  slot_nibble_a: assert property (
    wrTake && (paddr == pab_pkg::OFF_ARB_TABLE_WORD_1) && pstrb[0]
      |=> arbTable[3:0] == $past(pwdata[3:0]))
    else $error("slot 8 not held in low nibble");

  cap_id_a: assert property (
    pready && !pwrite && (paddr == pab_pkg::OFF_BUDGET_CAP_HDR)
      |-> prdata[15:0] == capHdr_r[15:0])
    else $error("capability identifier readback wrong");

  cap_ver_a: assert property (
    wrTake && (paddr == pab_pkg::OFF_BUDGET_CAP_HDR) && budgetWordUnlock_r && pstrb[2]
      |=> capHdr_r[19:16] == $past(pwdata[19:16]))
    else $error("capability version not stored");

  sel_field_a: assert property (
    wrTake && (paddr == pab_pkg::OFF_BUDGET_DATA_SEL) && pstrb[0]
      |=> dataWordSelector_r == $past(pwdata[7:0]))
    else $error("selector not stored");

  sel_range_a: assert property (
    pready && !pwrite && (paddr == pab_pkg::OFF_BUDGET_READBACK)
      && (dataWordSelector_r > pab_pkg::SEL_LAST_WORD)
      && $stable(dataWordSelector_r)
      |-> prdata == 32'h0000_0000)
    else $error("readback not zero for large selector");

  slot_valid_a: assert property (
    arbSlotValid[23] == pab_pkg::validPort(arbTable[95:92]))
    else $error("slot 31 validity flag wrong");

  readback_val_a: assert property (
    (phase_r == ST_FETCH) && !pwrite && (paddr == pab_pkg::OFF_BUDGET_READBACK)
      && (dataWordSelector_r <= pab_pkg::SEL_LAST_WORD)
      |=> prdata == $past(memRdata))
    else $error("readback does not match selected word");

  word_lock_a: assert property (
    memWe |-> budgetWordUnlock_r && isBudgetWord && pready)
    else $error("budget word written while locked");

  sel_reserved_a: assert property (
    pready && !pwrite && (paddr == pab_pkg::OFF_BUDGET_DATA_SEL)
      |-> prdata[31:8] == 24'h00_0000)
    else $error("selector reserved bits not zero");

  readback_word_a: assert property (
    pready && !pwrite && (paddr == pab_pkg::OFF_BUDGET_READBACK)
      && (dataWordSelector_r <= pab_pkg::SEL_LAST_WORD)
      && $stable(dataWordSelector_r)
      |-> prdata == memRdata)
    else $error("readback differs from selected data word");

  slot_code_a: assert property (
    arbSlotValid[0] == ((arbTable[3:0] == pab_pkg::PORT_UPSTREAM)
                     || (arbTable[3:0] == pab_pkg::PORT_TWO)
                     || (arbTable[3:0] == pab_pkg::PORT_FOUR)))
    else $error("slot 8 validity flag wrong");

  cap_lock_a: assert property (
    wrTake && (paddr == pab_pkg::OFF_BUDGET_CAP_HDR) && !budgetWordUnlock_r
      |=> $stable(capHdr_r))
    else $error("capability header written while locked");

  table_hold_a: assert property (
    !(wrTake && isTable) |=> $stable(arbTable))
    else $error("table changed without a table write");

endmodule

// >>> verif/pab_regs_tb.sv
// self-checking bench for the arbitration table and power budget bank.
// assumes pab_regs alone, driven over apb straight from this module.
`timescale 1ns/1ps
module pab_regs_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [95:0] arbTable;
  logic [23:0] arbSlotValid;
  int          miscompares;
  int          nTests;
  logic [31:0] rdVal;
  logic        errSeen;
  logic [31:0] tblWord [3];
  logic [23:0] expValid;
  logic [7:0]  badSel [3];

  pab_regs u_pab_regs (
    .clock        (clock),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .arbTable     (arbTable),
    .arbSlotValid (arbSlotValid)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic slotOk(input logic [3:0] code);
    slotOk = (code == 4'h0) || (code == 4'h2) || (code == 4'h4);
  endfunction

  task automatic chk(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
    nTests++;
    if (gotVal !== expVal)
    begin
      $display("wrong value %s expected %h seen %h", what, expVal, gotVal);
      miscompares++;
    end
  endtask

  // pready, prdata and pslverr are read at the rising edge, before the flops move
  task automatic xfer(input logic [11:0] addr, input logic wr, input logic [31:0] data,
                      input logic [3:0] strb);
    bit done;
    done = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= strb;
    @(posedge clock);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !done; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
      begin
        done    = 1;
        rdVal   = prdata;
        errSeen = pslverr;
      end
    end
    if (!done)
      chk("pready", 32'h1, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    xfer(addr, 1'b1, data, 4'hf);
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] expVal, input string what);
    xfer(addr, 1'b0, 32'h0, 4'hf);
    chk(what, expVal, rdVal);
    chk("pslverr", 32'h0, {31'h0, errSeen});
  endtask

  task automatic wrapUp();
    if (miscompares == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog: the whole sequence needs well under 1000 cycles
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    wrapUp();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    nTests      = 0;
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    tblWord     = '{32'h7654_3210, 32'hfedc_ba98, 32'h0402_4020};
    badSel      = '{8'h08, 8'h80, 8'hff};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int w = 0; w < 3; w++)
      rd(pab_pkg::OFF_ARB_TABLE_WORD_1 + 12'(4 * w), 32'h0, "table reset");
    chk("slot flags reset", 32'h00ff_ffff, {8'h0, arbSlotValid});
    rd(pab_pkg::OFF_BUDGET_CAP_HDR, 32'h0, "header reset");
    rd(pab_pkg::OFF_BUDGET_DATA_SEL, 32'h0, "select reset");
    // slot n of the table sits in word n/8, nibble n mod 8
    for (int w = 0; w < 3; w++)
      wr(pab_pkg::OFF_ARB_TABLE_WORD_1 + 12'(4 * w), tblWord[w]);
    for (int w = 0; w < 3; w++)
    begin
      rd(pab_pkg::OFF_ARB_TABLE_WORD_1 + 12'(4 * w), tblWord[w], "table word");
      chk("arbTable", tblWord[w], arbTable[32 * w +: 32]);
    end
    for (int n = 0; n < 24; n++)
      expValid[n] = slotOk(tblWord[n / 8][4 * (n % 8) +: 4]);
    chk("slot flags", {8'h0, expValid}, {8'h0, arbSlotValid});
    xfer(pab_pkg::OFF_ARB_TABLE_WORD_2, 1'b1, 32'h1111_1111, 4'h2);
    rd(pab_pkg::OFF_ARB_TABLE_WORD_2, 32'hfedc_1198, "byte strobe");
    // header stays locked until the unlock bit is set
    wr(pab_pkg::OFF_BUDGET_CAP_HDR, 32'hffff_ffff);
    rd(pab_pkg::OFF_BUDGET_CAP_HDR, 32'h0, "header locked");
    wr(pab_pkg::OFF_BUDGET_UNLOCK, 32'hffff_ffff);
    rd(pab_pkg::OFF_BUDGET_UNLOCK, 32'h1, "unlock");
    wr(pab_pkg::OFF_BUDGET_CAP_HDR, {12'habc, pab_pkg::CAP_VER_ONE, pab_pkg::CAP_ID_BUDGET});
    rd(pab_pkg::OFF_BUDGET_CAP_HDR, 32'habc1_0004, "header");
    for (int i = 0; i < 8; i++)
      wr(pab_pkg::OFF_BUDGET_WORD_BASE + 12'(4 * i), 32'hc0de_0000 + 32'(i));
    wr(pab_pkg::OFF_BUDGET_UNLOCK, 32'h0);
    wr(pab_pkg::OFF_BUDGET_WORD_BASE + 12'hc, 32'hdead_beef);
    rd(pab_pkg::OFF_BUDGET_WORD_BASE + 12'hc, 32'hc0de_0003, "locked word");
    for (int s = 0; s < 8; s++)
    begin
      wr(pab_pkg::OFF_BUDGET_DATA_SEL, 32'hffff_ff00 | 32'(s));
      rd(pab_pkg::OFF_BUDGET_DATA_SEL, 32'(s), "select");
      rd(pab_pkg::OFF_BUDGET_READBACK, 32'hc0de_0000 + 32'(s), "readback");
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(pab_pkg::OFF_BUDGET_DATA_SEL, {24'h0, badSel[k]});
      rd(pab_pkg::OFF_BUDGET_READBACK, 32'h0, "readback high select");
    end
    xfer(12'h230, 1'b0, 32'h0, 4'hf);
    chk("unmapped pslverr", 32'h1, {31'h0, errSeen});
    chk("unmapped prdata", 32'h0, rdVal);
    // second reset in mid-run: table and header clear, data words are sticky
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    chk("arbTable after reset", 32'h0, arbTable[31:0]);
    rd(pab_pkg::OFF_ARB_TABLE_WORD_3, 32'h0, "table after reset");
    rd(pab_pkg::OFF_BUDGET_CAP_HDR, 32'h0, "header after reset");
    rd(pab_pkg::OFF_BUDGET_READBACK, 32'hc0de_0000, "sticky word");
    wrapUp();
  end
endmodule
